// File: inc/status_flags_pkg.sv
// Purpose: shared constants and carriers for the core status flags block
// Assumes: 8-bit flags register, Avalon-MM slave with 32-bit data
// Notes:   one register word at byte address STATUS_OFS
package status_flags_pkg;

  // ==========================================================
  // widths and register map
  localparam int             DATA_W     = 8;
  localparam int             BUS_AW     = 4;
  localparam int             BUS_DW     = 32;
  localparam logic [3:0]     STATUS_OFS = 4'h0;

  // ==========================================================
  // field positions
  localparam int             BIT_CARRY  = 0;
  localparam int             BIT_NIBBLE = 1;
  localparam int             BIT_NULL   = 2;
  localparam int             BIT_PDOWN  = 3;
  localparam int             BIT_WDEXP  = 4;
  localparam int             NIBBLE_W   = 4;

  // ==========================================================
  // reset values after power-on or brown-out
  localparam logic           RST_ARITH  = 1'b0;
  localparam logic           RST_CAUSE  = 1'b1;
  localparam logic [2:0]     UNIMP_VAL  = 3'h0;

  // ==========================================================
  // operation kinds presented by the core
  typedef enum logic [1:0] {
    OP_ADD   = 2'b00,
    OP_SUB   = 2'b01,
    OP_LOGIC = 2'b10,
    OP_NONE  = 2'b11
  } alu_op_t;

  // one ALU result offered for flag update
  typedef struct packed {
    logic                valid;
    alu_op_t             op;
    logic [DATA_W-1:0]   a;
    logic [DATA_W-1:0]   b;
    logic [DATA_W-1:0]   logic_res;
  } alu_req_t;

  // instruction write with the flags register as destination
  typedef struct packed {
    logic                valid;
    logic [DATA_W-1:0]   data;
  } core_wr_t;

  // reset-cause events from watchdog and sleep logic
  typedef struct packed {
    logic                wdt_timeout;
    logic                watchdog_clear_instruction;
    logic                sleep_instruction;
  } cause_evt_t;

endpackage

// File: src/core_status_flags.sv
// Purpose: processor status flags register with Avalon-MM access
// Assumes: core inputs are synchronous to MCLK; NRST is power-on/brown-out
// Notes:   bus answers one cycle after a request is first seen
//
// What this block does
// RQ1: bits 7 to 5 read zero; writes to them are dropped.
// RQ2: watchdog expiry flag set by power-up, watchdog clear, or sleep.
// RQ3: watchdog time-out clears the watchdog expiry flag.
// RQ4: sleep clears power-down flag; power-up or watchdog clear sets it.
// RQ5: result-null flag follows whether the ALU result is zero.
// RQ6: nibble carry flag is the carry out of result bit 3.
// RQ7: on subtract both carry flags mean no borrow when one.
// RQ8: subtract adds the two's complement of the second operand.
// RQ9: cause flags read-only, reset to one; arithmetic flags RW, reset zero.
// RQ10: full carry flag is the carry out of the top result bit.
// RQ11: ALU flag results beat a same-cycle write to the register.
// RQ12: writes to watchdog expiry and power-down flags are ignored.
`timescale 1ns/10ps

module core_status_flags
  import status_flags_pkg::*;
(
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                NRST,
  // core side
  input  wire alu_req_t            ALU_REQ,
  input  wire core_wr_t            CORE_WR,
  input  wire cause_evt_t          CAUSE_EVT,
  output logic [DATA_W-1:0]        STATUS_OUT,
  // avalon-mm slave
  input  wire logic [BUS_AW-1:0]   AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [BUS_DW-1:0]   AVS_WRITEDATA,
  output logic [BUS_DW-1:0]        AVS_READDATA,
  output logic                     AVS_WAITREQUEST
);

  // ==========================================================
  // adder used for both add and subtract
  function automatic logic [DATA_W+1:0] add_flags(
    input logic [DATA_W-1:0] x,
    input logic [DATA_W-1:0] y,
    input logic              cin
  );
    logic [DATA_W:0]     full;
    logic [NIBBLE_W:0]   low;
    full = {1'b0, x} + {1'b0, y} + {{DATA_W{1'b0}}, cin};
    low  = {1'b0, x[NIBBLE_W-1:0]} + {1'b0, y[NIBBLE_W-1:0]}
         + {{NIBBLE_W{1'b0}}, cin};
    // {carry, nibble carry, result}
    add_flags = {full[DATA_W], low[NIBBLE_W], full[DATA_W-1:0]};
  endfunction

  // ==========================================================
  // reset release
  logic                rst_meta_q;
  logic                rst_sync_q;

  // two-stage release of the async reset
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // every other register resets from this released copy
  wire logic rst_n = rst_sync_q;

  // ==========================================================
  // flag state
  logic                carry_q;
  logic                nibble_carry_flag_q;
  logic                null_q;
  logic                watchdog_expiry_flag_q;
  logic                powerdown_flag_q;
  logic                waitreq_q;
  logic [BUS_DW-1:0]   rdata_q;
  logic [DATA_W-1:0]   status_q;

  // ==========================================================
  // ALU flag computation
  logic [DATA_W+1:0]   sum_w;
  logic [DATA_W-1:0]   res_w;
  logic                is_arith;
  logic                alu_hit;

  always_comb begin
    is_arith = ALU_REQ.op inside {OP_ADD, OP_SUB};
    alu_hit  = ALU_REQ.valid && (ALU_REQ.op != OP_NONE);
    if (ALU_REQ.op == OP_SUB) begin
      sum_w = add_flags(ALU_REQ.a, ~ALU_REQ.b, 1'b1); // RQ8 RQ7
    end else begin
      sum_w = add_flags(ALU_REQ.a, ALU_REQ.b, 1'b0);
    end
    if (is_arith) begin
      res_w = sum_w[DATA_W-1:0];
    end else begin
      res_w = ALU_REQ.logic_res;
    end
  end

  // ==========================================================
  // write sources for the arithmetic flags
  // only bits 2:0 of a write ever reach state; bits 7:3 have no
  // write path, so the cause flags keep their hardware values
  logic                bus_wr;
  logic                bus_sel;
  logic [DATA_W-1:0]   wr_val;
  logic                wr_hit;

  always_comb begin
    bus_sel = (AVS_ADDRESS == STATUS_OFS);
    bus_wr  = AVS_WRITE && !waitreq_q && bus_sel;
    wr_hit  = CORE_WR.valid || bus_wr;
    // core instruction write takes the bus write's place
    if (CORE_WR.valid) begin
      wr_val = CORE_WR.data;
    end else begin
      wr_val = AVS_WRITEDATA[DATA_W-1:0]; // RQ1 RQ12
    end
  end

  // ==========================================================
  // result-null flag
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      null_q <= RST_ARITH; // RQ9
    end else if (alu_hit) begin
      null_q <= (res_w == '0); // RQ5 RQ11
    end else if (wr_hit) begin
      null_q <= wr_val[BIT_NULL];
    end
  end

  // ==========================================================
  // carry flags, touched by add and subtract results and by writes
  // any ALU result other than OP_NONE blocks a write here, even a logic op
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      carry_q             <= RST_ARITH; // RQ9
      nibble_carry_flag_q <= RST_ARITH;
    end else if (alu_hit && is_arith) begin
      carry_q             <= sum_w[DATA_W+1]; // RQ10 RQ7 RQ11
      nibble_carry_flag_q <= sum_w[DATA_W];   // RQ6 RQ7
    end else if (wr_hit && !alu_hit) begin
      carry_q             <= wr_val[BIT_CARRY];
      nibble_carry_flag_q <= wr_val[BIT_NIBBLE];
    end
  end

  // ==========================================================
  // reset-cause flags, never written by software
  // clear and sleep events set the expiry flag again
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_expiry_flag_q <= RST_CAUSE; // RQ2 RQ9
      powerdown_flag_q       <= RST_CAUSE; // RQ4 RQ9
    end else begin
      // time-out wins over clear or sleep in the same cycle
      if (CAUSE_EVT.wdt_timeout) begin
        watchdog_expiry_flag_q <= 1'b0; // RQ3
      end else if (CAUSE_EVT.watchdog_clear_instruction ||
                   CAUSE_EVT.sleep_instruction) begin
        watchdog_expiry_flag_q <= 1'b1; // RQ2 RQ12
      end
      if (CAUSE_EVT.sleep_instruction) begin
        powerdown_flag_q <= 1'b0; // RQ4 RQ12
      end else if (CAUSE_EVT.watchdog_clear_instruction) begin
        powerdown_flag_q <= 1'b1; // RQ4
      end
    end
  end

  // ==========================================================
  // assembled register value
  logic [DATA_W-1:0]   status_w;

  always_comb begin
    status_w = {UNIMP_VAL, watchdog_expiry_flag_q, powerdown_flag_q,
                null_q, nibble_carry_flag_q, carry_q}; // RQ1
  end

  // registered copy towards the core
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= {UNIMP_VAL, RST_CAUSE, RST_CAUSE,
                   RST_ARITH, RST_ARITH, RST_ARITH};
    end else begin
      status_q <= status_w;
    end
  end

  assign STATUS_OUT = status_q;

  // ==========================================================
  // avalon-mm handshake: one wait cycle, then a one-cycle answer
  // a write lands only at the edge that sees waitrequest low
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_q <= 1'b1;
      rdata_q   <= '0;
    end else if ((AVS_READ || AVS_WRITE) && waitreq_q) begin
      waitreq_q <= 1'b0;
      if (AVS_READ && bus_sel) begin
        rdata_q <= {{(BUS_DW-DATA_W){1'b0}}, status_w}; // RQ1
      end else begin
        rdata_q <= '0; // unmapped reads as zero
      end
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  assign AVS_WAITREQUEST = waitreq_q;
  assign AVS_READDATA    = rdata_q;

endmodule

// File: verif/status_flags_sva.sv
// Purpose: port assertions for the flags block
// Assumes: one clock; NRST is the power-on reset
// Notes:   flag effects reach STATUS_OUT two edges after cause
`timescale 1ns/10ps
// ==========================
// checker
module status_flags_sva
  import status_flags_pkg::*;
(
  // clock and reset
  input wire logic        MCLK,
  input wire logic        NRST,
  // core side
  input wire alu_req_t    ALU_REQ,
  input wire core_wr_t    CORE_WR,
  input wire cause_evt_t  CAUSE_EVT,
  input wire logic [7:0]  STATUS_OUT,
  // bus
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);
  // zero, nibble and full carry of a + b, or of a + ~b + 1
  function automatic logic [2:0] fl(logic [7:0] a, logic [7:0] b, logic s);
    logic [7:0] bb;
    logic [8:0] r;
    logic [4:0] n;
    bb = s ? ~b : b;
    r = {1'b0, a} + {1'b0, bb} + 9'(s);
    n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(s);
    return {r[7:0] == 8'h00, n[4], r[8]};
  endfunction
  sequence s_op(alu_op_t o);
    ALU_REQ.valid && ALU_REQ.op == o;
  endsequence
  sequence s_ans;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  property p_unimp;
    STATUS_OUT[7:5] == 3'h0;
  endproperty
  property p_tmo;
    CAUSE_EVT.wdt_timeout |-> ##2 !STATUS_OUT[4];
  endproperty
  property p_clr;
    CAUSE_EVT == 3'h2 |-> ##2 STATUS_OUT[4:3] == 2'h3;
  endproperty
  property p_slp;
    CAUSE_EVT == 3'h1 |-> ##2 STATUS_OUT[4:3] == 2'h2;
  endproperty
  property p_add;
    s_op(OP_ADD) |-> ##2
      STATUS_OUT[2:0] == $past(fl(ALU_REQ.a, ALU_REQ.b, 1'b0), 2);
  endproperty
  property p_sub;
    s_op(OP_SUB) |-> ##2
      STATUS_OUT[2:0] == $past(fl(ALU_REQ.a, ALU_REQ.b, 1'b1), 2);
  endproperty
  property p_log;
    s_op(OP_LOGIC) ##0 (!CORE_WR.valid && !AVS_WRITE) |-> ##2
      STATUS_OUT[2:0] == {$past(ALU_REQ.logic_res == 8'h00, 2),
                          $past(STATUS_OUT[1:0])};
  endproperty
  property p_cwr;
    CORE_WR.valid && !ALU_REQ.valid && CAUSE_EVT == 3'h0 |-> ##2
      STATUS_OUT[4:0] == {$past(STATUS_OUT[4:3]), $past(CORE_WR.data[2:0], 2)};
  endproperty
  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_ans;
  endproperty
  property p_rdat;
    AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:5] == 27'h0 &&
      (AVS_ADDRESS == STATUS_OFS || AVS_READDATA == 32'h0);
  endproperty
  a_unimp: assert property (p_unimp) else $error("upper bits set");
  a_tmo: assert property (p_tmo) else $error("timeout flag");
  a_clr: assert property (p_clr) else $error("clear flags");
  a_slp: assert property (p_slp) else $error("sleep flags");
  a_add: assert property (p_add) else $error("add flags");
  a_sub: assert property (p_sub) else $error("sub flags");
  a_log: assert property (p_log) else $error("logic flags");
  a_cwr: assert property (p_cwr) else $error("core write");
  a_wait: assert property (p_wait) else $error("wait low cycle");
  a_rdat: assert property (p_rdat) else $error("read data");
endmodule
bind core_status_flags status_flags_sva u_sva (
  .MCLK            (MCLK),
  .NRST            (NRST),
  .ALU_REQ         (ALU_REQ),
  .CORE_WR         (CORE_WR),
  .CAUSE_EVT       (CAUSE_EVT),
  .STATUS_OUT      (STATUS_OUT),
  .AVS_ADDRESS     (AVS_ADDRESS),
  .AVS_READ        (AVS_READ),
  .AVS_WRITE       (AVS_WRITE),
  .AVS_READDATA    (AVS_READDATA),
  .AVS_WAITREQUEST (AVS_WAITREQUEST)
);

// File: verif/core_status_flags_bench.sv
// Purpose: self-checking bench for the flags block
// Assumes: bus answers within a few cycles
// Notes:   flags are read back over the bus and on STATUS_OUT
`timescale 1ns/10ps
// ==========================
// bench
module core_status_flags_bench;
  import status_flags_pkg::*;
  logic        MCLK = 1'b0, NRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  alu_req_t    ALU_REQ;
  core_wr_t    CORE_WR;
  cause_evt_t  CAUSE_EVT;
  logic [7:0]  STATUS_OUT;
  logic [3:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  int          n_fail, checks;
  core_status_flags u_dut (
    .MCLK            (MCLK),
    .NRST            (NRST),
    .ALU_REQ         (ALU_REQ),
    .CORE_WR         (CORE_WR),
    .CAUSE_EVT       (CAUSE_EVT),
    .STATUS_OUT      (STATUS_OUT),
    .AVS_ADDRESS     (AVS_ADDRESS),
    .AVS_READ        (AVS_READ),
    .AVS_WRITE       (AVS_WRITE),
    .AVS_WRITEDATA   (AVS_WRITEDATA),
    .AVS_READDATA    (AVS_READDATA),
    .AVS_WAITREQUEST (AVS_WAITREQUEST)
  );
  always #10 MCLK = ~MCLK;
  task check(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is seen low
  task bus(logic wr, logic [3:0] a, logic [31:0] d);
    int i;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge MCLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      close_out;
    end else begin
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      @(posedge MCLK);
    end
  endtask
  task rd(logic [3:0] a, logic [7:0] e);
    bus(1'b0, a, 32'h0);
    check(q, {24'h0, e});
  endtask
  task sr(logic [7:0] e);
    rd(STATUS_OFS, e);
    check(STATUS_OUT, e);
  endtask
  task pulse(alu_req_t r, core_wr_t w, cause_evt_t e);
    ALU_REQ <= r;
    CORE_WR <= w;
    CAUSE_EVT <= e;
    @(posedge MCLK);
    ALU_REQ <= '0;
    CORE_WR <= '0;
    CAUSE_EVT <= '0;
  endtask
  task rst(int n);
    NRST <= 1'b0;
    repeat (n) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (4) @(posedge MCLK);
  endtask
  alu_req_t   ar[8] = '{'{1, OP_ADD, 8'h0F, 8'h01, 0},
    '{1, OP_ADD, 8'hFF, 8'h01, 0}, '{1, OP_ADD, 8'h10, 8'h20, 0},
    '{1, OP_SUB, 8'h05, 8'h03, 0}, '{1, OP_SUB, 8'h03, 8'h05, 0},
    '{1, OP_SUB, 8'h05, 8'h05, 0}, '{1, OP_LOGIC, 0, 0, 8'h00},
    '{1, OP_LOGIC, 0, 0, 8'h05}};
  logic [2:0] ex[8] = '{3'h2, 3'h7, 3'h0, 3'h3, 3'h0, 3'h7, 3'h7, 3'h3};
  // last event: time-out and clear together, time-out wins on bit 4
  logic [2:0] ce[5] = '{3'h4, 3'h1, 3'h4, 3'h2, 3'h6};
  logic [7:0] cx[5] = '{8'h0A, 8'h12, 8'h02, 8'h1A, 8'h0A};
  alu_req_t   nop = '{1'b1, OP_NONE, 8'hFF, 8'h01, 8'h00};
  // main sequence
  initial begin
    {ALU_REQ, CORE_WR, CAUSE_EVT, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    {AVS_READ, AVS_WRITE} = 2'h0;
    rst(12);
    sr(8'h18);
    $display("test reset done");
    bus(1'b1, STATUS_OFS, 32'hFFFFFFE7);
    sr(8'h1F);
    bus(1'b1, 4'h4, 32'h0);
    rd(4'h4, 8'h00);
    sr(8'h1F);
    bus(1'b1, STATUS_OFS, 32'h0);
    sr(8'h18);
    $display("test bus done");
    for (int i = 0; i < 8; i++) begin
      pulse(ar[i], '0, '0);
      sr({5'h03, ex[i]});
    end
    // a no-op result must leave every flag alone
    pulse(nop, '0, '0);
    sr(8'h1B);
    $display("test alu done");
    pulse(ar[1], '{1'b1, 8'h00}, '0);
    sr(8'h1F);
    pulse('0, '{1'b1, 8'hE2}, '0);
    sr(8'h1A);
    $display("test core write done");
    for (int i = 0; i < 5; i++) begin
      pulse('0, '0, ce[i]);
      sr(cx[i]);
    end
    $display("test cause done");
    rst(3);
    sr(8'h18);
    $display("test second reset done");
    close_out;
  end
endmodule
